/* File: src/sba_alarm.sv */
`timescale 1ns/1ns
`include "sba_consts.svh"
// What this block does
// [RQ1] six bands, limits and two thresholds each
// [RQ2] limits stored per band and rate option
// [RQ3] response delay counts alarming records
// [RQ4] bit 7 latches error flags until clear
// [RQ5] bit 6 routes warning and fault pins
// [RQ6] bit 5 picks below or above compare
// [RQ7] bit 4 picks temperature or supply
// [RQ8] bit 3 enables system alarm
// [RQ9] bits 1,0 enable y and x axes
// [RQ10] config resets to 0x0080, unused bits zero
// [RQ11] pointer bits 2:0 select band
// [RQ12] pointer bits 9:8 select rate option
// [RQ13] low-limit byte holds lower bin
// [RQ14] high-limit byte holds upper bin
// [RQ15] host sets pointer before writing limits
// [RQ16] host converts frequency to bin number
// [RQ17] warning and fault levels per axis
// [RQ18] system level compared with measurement
// [RQ19] axis and general status readable
// [RQ20] worst peak and bin per axis
// [RQ21] host keeps fault above warning
// [RQ22] status word bands and critical band
// [RQ23] clear and save band commands
// [RQ24] flag band when bin exceeds threshold
module sba_alarm
    import sba_pkg::*;
#(
    parameter int BANDS = 6,
    parameter int RATES = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    // global command word strobe
    input wire logic cmd_valid_in,
    input wire logic [15:0] global_command_in,
    // spectral record stream: one bin per cycle per axis
    input wire logic rec_start_in,
    input wire logic rec_valid_in,
    input wire logic rec_last_in,
    input wire logic [1:0] rec_rate_in,
    input wire logic [7:0] rec_bin_in,
    input wire logic [15:0] rec_x_mag_in,
    input wire logic [15:0] rec_y_mag_in,
    // system measurements
    input wire logic [15:0] temp_meas_in,
    input wire logic [15:0] supply_meas_in,
    // alarm outputs
    output logic warning_output_pin_out,
    output logic fault_output_pin_out,
    output logic bands_saved_out
);
    localparam int NL = BANDS * RATES;
    // whole module state
    typedef struct packed {
        logic [NL-1:0][15:0] limits;  // {high,low} per band*rate
        logic [15:0] x_warn;
        logic [15:0] y_warn;
        logic [15:0] x_fault;
        logic [15:0] y_fault;
        logic [15:0] pointer;
        logic [15:0] sys_level;
        logic [15:0] config_r;
        logic [15:0] gen_stat;
        logic [15:0] x_stat;
        logic [15:0] y_stat;
        logic [15:0] x_peak;
        logic [15:0] y_peak;
        logic [15:0] x_bin;
        logic [15:0] y_bin;
        logic [BANDS-1:0][1:0] x_hit;  // {fault,warn} this record
        logic [BANDS-1:0][1:0] y_hit;
        logic [BANDS-1:0][1:0][3:0] x_cnt;  // consecutive alarm records
        logic [BANDS-1:0][1:0][3:0] y_cnt;
        logic [15:0] xr_peak;  // running worst this record
        logic [15:0] yr_peak;
        logic [7:0] xr_bin;
        logic [7:0] yr_bin;
        logic [1:0] rate;
        logic written;  // limits touched since clear
        logic saved;
        sba_phase_t phase;
    } sba_state_t;

    sba_state_t st_ff;
    sba_state_t nxt_st;

    // comparator results per band
    logic [BANDS-1:0] xw;
    logic [BANDS-1:0] xf;
    logic [BANDS-1:0] yw;
    logic [BANDS-1:0] yf;
    // limit entry index for pointer access
    logic [7:0] ptr_idx;
    logic ptr_ok;
    logic [15:0] sys_meas;
    logic sys_alarm;

    // pointer band 1..6 maps to entry (band-1)*RATES+rate
    always_comb begin
        ptr_idx = 8'((st_ff.pointer[2:0] - 3'd1) * RATES) + 8'(st_ff.pointer[9:8]); // RQ11 RQ12
        ptr_ok = (st_ff.pointer[2:0] >= 3'd1) && (st_ff.pointer[2:0] <= 3'(BANDS));
    end

    // one comparator per band and axis; limits for record rate
    genvar g;
    generate
        for (g = 0; g < BANDS; g++) begin : g_band // RQ1
            sba_cmp_if xi();
            sba_cmp_if yi();
            assign xi.bin = rec_bin_in;
            assign xi.low = st_ff.limits[g * RATES + st_ff.rate][7:0];
            assign xi.high = st_ff.limits[g * RATES + st_ff.rate][15:8];
            assign xi.mag = rec_x_mag_in;
            assign xi.warn_lvl = st_ff.x_warn; // RQ17
            assign xi.fault_lvl = st_ff.x_fault;
            assign yi.bin = rec_bin_in;
            assign yi.low = st_ff.limits[g * RATES + st_ff.rate][7:0];
            assign yi.high = st_ff.limits[g * RATES + st_ff.rate][15:8];
            assign yi.mag = rec_y_mag_in;
            assign yi.warn_lvl = st_ff.y_warn;
            assign yi.fault_lvl = st_ff.y_fault;
            sba_band_cmp u_x (.c(xi));
            sba_band_cmp u_y (.c(yi));
            assign xw[g] = xi.warn_hit;
            assign xf[g] = xi.fault_hit;
            assign yw[g] = yi.warn_hit;
            assign yf[g] = yi.fault_hit;
        end
    endgenerate

    // system alarm compare, selected source and polarity
    always_comb begin
        sys_meas = st_ff.config_r[`SBA_CFG_SYS_TEMP] ? temp_meas_in : supply_meas_in; // RQ7
        sys_alarm = 1'b0;
        if (st_ff.config_r[`SBA_CFG_SYS_EN]) begin // RQ8
            if (st_ff.config_r[`SBA_CFG_SYS_BELOW]) begin
                sys_alarm = sys_meas < st_ff.sys_level; // RQ6 RQ18
            end else begin
                sys_alarm = sys_meas > st_ff.sys_level; // RQ6
            end
        end
    end

    // next-state logic
    always_comb begin
        logic [3:0] dly;
        logic [15:0] xs;
        logic [15:0] ys;
        logic xbad;
        logic ybad;
        dly = 4'h0;
        xs = `SBA_ZERO16;
        ys = `SBA_ZERO16;
        xbad = 1'b0;
        ybad = 1'b0;
        nxt_st = st_ff;
        dly = st_ff.config_r[`SBA_CFG_DLY_LO +: 4];
        // register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                `SBA_OFS_LOW_BIN: begin
                    if (ptr_ok) begin
                        nxt_st.limits[ptr_idx][7:0] = reg_wdata_in[7:0]; // RQ2 RQ13
                        nxt_st.written = 1'b1;
                    end
                end
                `SBA_OFS_HIGH_BIN: begin
                    if (ptr_ok) begin
                        nxt_st.limits[ptr_idx][15:8] = reg_wdata_in[7:0]; // RQ2 RQ14
                        nxt_st.written = 1'b1;
                    end
                end
                `SBA_OFS_X_WARN: nxt_st.x_warn = reg_wdata_in; // RQ17
                `SBA_OFS_Y_WARN: nxt_st.y_warn = reg_wdata_in;
                `SBA_OFS_X_FAULT: nxt_st.x_fault = reg_wdata_in;
                `SBA_OFS_Y_FAULT: nxt_st.y_fault = reg_wdata_in;
                `SBA_OFS_POINTER: nxt_st.pointer = reg_wdata_in & `SBA_PTR_MASK; // RQ12
                `SBA_OFS_SYS_LEVEL: nxt_st.sys_level = reg_wdata_in; // RQ18
                `SBA_OFS_CONFIG: nxt_st.config_r = reg_wdata_in & `SBA_CFG_MASK; // RQ10
                default: ;  // read-only or unmapped: ignored
            endcase
        end
        // global commands
        if (cmd_valid_in) begin
            if (global_command_in[`SBA_CMD_CLR_BANDS]) begin
                nxt_st.limits = '0; // RQ23
                nxt_st.written = 1'b0;
                nxt_st.saved = 1'b0;
            end
            // save refused once any location was written
            if (global_command_in[`SBA_CMD_SAVE] && !st_ff.written) begin
                nxt_st.saved = 1'b1; // RQ23
            end
            if (global_command_in[`SBA_CMD_CLR_STAT]) begin
                nxt_st.gen_stat = `SBA_ZERO16; // RQ4
            end
        end
        // system alarm flag: latched or live; set wins over clear
        if (st_ff.config_r[`SBA_CFG_LATCH]) begin
            if (sys_alarm) begin
                nxt_st.gen_stat[0] = 1'b1; // RQ4
            end
        end else begin
            nxt_st.gen_stat[0] = sys_alarm; // RQ4
        end
        // record scan phases
        unique case (st_ff.phase)
            SBA_IDLE: begin
                if (rec_start_in) begin
                    nxt_st.rate = rec_rate_in;
                    nxt_st.x_hit = '0;
                    nxt_st.y_hit = '0;
                    nxt_st.xr_peak = `SBA_ZERO16;
                    nxt_st.yr_peak = `SBA_ZERO16;
                    nxt_st.phase = SBA_SCAN;
                end
            end
            SBA_SCAN: begin
                if (rec_valid_in) begin
                    for (int b = 0; b < BANDS; b++) begin
                        if (xw[b]) nxt_st.x_hit[b][0] = 1'b1; // RQ24
                        if (xf[b]) nxt_st.x_hit[b][1] = 1'b1;
                        if (yw[b]) nxt_st.y_hit[b][0] = 1'b1;
                        if (yf[b]) nxt_st.y_hit[b][1] = 1'b1;
                    end
                    // worst in-band magnitude per axis
                    if ((|xw) && rec_x_mag_in > st_ff.xr_peak) begin
                        nxt_st.xr_peak = rec_x_mag_in; // RQ20
                        nxt_st.xr_bin = rec_bin_in;
                    end
                    if ((|yw) && rec_y_mag_in > st_ff.yr_peak) begin
                        nxt_st.yr_peak = rec_y_mag_in;
                        nxt_st.yr_bin = rec_bin_in;
                    end
                    if (rec_last_in) begin
                        nxt_st.phase = SBA_DONE;
                    end
                end
            end
            SBA_DONE: begin
                // count consecutive alarming records per band/level
                for (int b = 0; b < BANDS; b++) begin
                    for (int l = 0; l < 2; l++) begin
                        if (!st_ff.config_r[`SBA_CFG_X_EN] || !st_ff.x_hit[b][l]) begin
                            nxt_st.x_cnt[b][l] = 4'h0; // RQ9
                        end else if (st_ff.x_cnt[b][l] != 4'hF) begin
                            nxt_st.x_cnt[b][l] = st_ff.x_cnt[b][l] + 4'h1; // RQ3
                        end
                        if (!st_ff.config_r[`SBA_CFG_Y_EN] || !st_ff.y_hit[b][l]) begin
                            nxt_st.y_cnt[b][l] = 4'h0; // RQ9
                        end else if (st_ff.y_cnt[b][l] != 4'hF) begin
                            nxt_st.y_cnt[b][l] = st_ff.y_cnt[b][l] + 4'h1;
                        end
                // flag on record delay+1; prior count saturates at 15 so delay 15 still fires
                        xs[4 + 2 * b + l] = |nxt_st.x_cnt[b][l] && st_ff.x_cnt[b][l] >= dly; // RQ3
                        ys[4 + 2 * b + l] = |nxt_st.y_cnt[b][l] && st_ff.y_cnt[b][l] >= dly;
                    end
                end
                // most critical band: lowest-numbered fault band, else lowest-numbered warning band
                for (int b = 0; b < BANDS; b++) begin
                    if (xs[4 + 2 * b] && !xbad && xs[2:0] == 3'd0) xs[2:0] = 3'(b + 1);
                    if (ys[4 + 2 * b] && !ybad && ys[2:0] == 3'd0) ys[2:0] = 3'(b + 1);
                end
                for (int b = 0; b < BANDS; b++) begin
                    if (xs[5 + 2 * b] && !xbad) begin
                        xs[2:0] = 3'(b + 1); // RQ22
                        xbad = 1'b1;
                    end
                    if (ys[5 + 2 * b] && !ybad) begin
                        ys[2:0] = 3'(b + 1);
                        ybad = 1'b1;
                    end
                end
                nxt_st.x_stat = xs; // RQ19
                nxt_st.y_stat = ys;
                nxt_st.x_peak = (|xs[15:4]) ? st_ff.xr_peak : `SBA_ZERO16; // RQ20
                nxt_st.y_peak = (|ys[15:4]) ? st_ff.yr_peak : `SBA_ZERO16;
                nxt_st.x_bin = (|xs[15:4]) ? {8'h00, st_ff.xr_bin} : `SBA_ZERO16;
                nxt_st.y_bin = (|ys[15:4]) ? {8'h00, st_ff.yr_bin} : `SBA_ZERO16;
                // spectral flags in general status, latched or live
                if (st_ff.config_r[`SBA_CFG_LATCH]) begin
                    if (|xs[15:4]) nxt_st.gen_stat[1] = 1'b1; // RQ4
                    if (|ys[15:4]) nxt_st.gen_stat[2] = 1'b1;
                end else begin
                    nxt_st.gen_stat[1] = |xs[15:4];
                    nxt_st.gen_stat[2] = |ys[15:4];
                end
                nxt_st.phase = SBA_IDLE;
            end
            default: nxt_st.phase = SBA_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.config_r <= `SBA_CONFIG_RST; // RQ10
            st_ff.phase <= SBA_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // register read mux
    always_comb begin
        unique case (reg_addr_in)
            `SBA_OFS_LOW_BIN: reg_rdata_out = ptr_ok ? {8'h00, st_ff.limits[ptr_idx][7:0]} : '0;
            `SBA_OFS_HIGH_BIN: reg_rdata_out = ptr_ok ? {8'h00, st_ff.limits[ptr_idx][15:8]} : '0;
            `SBA_OFS_X_WARN: reg_rdata_out = st_ff.x_warn;
            `SBA_OFS_Y_WARN: reg_rdata_out = st_ff.y_warn;
            `SBA_OFS_X_FAULT: reg_rdata_out = st_ff.x_fault;
            `SBA_OFS_Y_FAULT: reg_rdata_out = st_ff.y_fault;
            `SBA_OFS_POINTER: reg_rdata_out = st_ff.pointer;
            `SBA_OFS_SYS_LEVEL: reg_rdata_out = st_ff.sys_level;
            `SBA_OFS_CONFIG: reg_rdata_out = st_ff.config_r;
            `SBA_OFS_GEN_STAT: reg_rdata_out = st_ff.gen_stat; // RQ19
            `SBA_OFS_X_STAT: reg_rdata_out = st_ff.x_stat;
            `SBA_OFS_Y_STAT: reg_rdata_out = st_ff.y_stat;
            `SBA_OFS_X_PEAK: reg_rdata_out = st_ff.x_peak; // RQ20
            `SBA_OFS_Y_PEAK: reg_rdata_out = st_ff.y_peak;
            `SBA_OFS_X_BIN: reg_rdata_out = st_ff.x_bin;
            `SBA_OFS_Y_BIN: reg_rdata_out = st_ff.y_bin;
            default: reg_rdata_out = `SBA_ZERO16;  // unmapped reads zero
        endcase
    end

    // pins follow status only when routed to alarms
    assign warning_output_pin_out = st_ff.config_r[`SBA_CFG_PIN_EN] &&
        (|{st_ff.x_stat[14], st_ff.x_stat[12], st_ff.x_stat[10], st_ff.x_stat[8],
           st_ff.x_stat[6], st_ff.x_stat[4], st_ff.y_stat[14], st_ff.y_stat[12],
           st_ff.y_stat[10], st_ff.y_stat[8], st_ff.y_stat[6], st_ff.y_stat[4]}); // RQ5
    assign fault_output_pin_out = st_ff.config_r[`SBA_CFG_PIN_EN] &&
        (|{st_ff.x_stat[15], st_ff.x_stat[13], st_ff.x_stat[11], st_ff.x_stat[9],
           st_ff.x_stat[7], st_ff.x_stat[5], st_ff.y_stat[15], st_ff.y_stat[13],
           st_ff.y_stat[11], st_ff.y_stat[9], st_ff.y_stat[7], st_ff.y_stat[5]}); // RQ5
    assign bands_saved_out = st_ff.saved;

    a_cfg_reset: assert property (@(posedge core_clk_in) $rose(rst_n_in) |->
        st_ff.config_r == `SBA_CONFIG_RST) else $error("config reset wrong"); // RQ10
    a_pin_gate: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !st_ff.config_r[`SBA_CFG_PIN_EN] |-> !warning_output_pin_out && !fault_output_pin_out)
        else $error("pin active while disabled"); // RQ5
    a_x_disable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        st_ff.phase == SBA_DONE && !st_ff.config_r[`SBA_CFG_X_EN] |=> st_ff.x_stat == 16'h0000)
        else $error("x status with axis off"); // RQ9
    a_sys_latch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        st_ff.config_r[`SBA_CFG_LATCH] && st_ff.gen_stat[0] && !cmd_valid_in |=> st_ff.gen_stat[0])
        else $error("latched flag dropped"); // RQ4
    a_sys_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !st_ff.config_r[`SBA_CFG_SYS_EN] && !st_ff.config_r[`SBA_CFG_LATCH] |=> !st_ff.gen_stat[0])
        else $error("system alarm while off"); // RQ8
    a_sys_cmp: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        sys_alarm |-> (st_ff.config_r[`SBA_CFG_SYS_BELOW] ? sys_meas < st_ff.sys_level
                       : sys_meas > st_ff.sys_level)) else $error("system compare wrong"); // RQ6
    a_save_refuse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        st_ff.written && !st_ff.saved |=> !st_ff.saved) else $error("save accepted"); // RQ23
    a_crit_band: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        st_ff.phase == SBA_DONE ##1 (st_ff.x_stat[15:4] == 12'h000) |-> st_ff.x_stat[2:0] == 3'd0)
        else $error("critical band without flag"); // RQ22
endmodule

/* File: pkg/sba_consts.svh */
`ifndef SBA_CONSTS_SVH
`define SBA_CONSTS_SVH
// register byte offsets
`define SBA_OFS_LOW_BIN   8'h20
`define SBA_OFS_HIGH_BIN  8'h22
`define SBA_OFS_X_WARN    8'h24
`define SBA_OFS_Y_WARN    8'h26
`define SBA_OFS_X_FAULT   8'h28
`define SBA_OFS_Y_FAULT   8'h2A
`define SBA_OFS_POINTER   8'h2C
`define SBA_OFS_SYS_LEVEL 8'h2E
`define SBA_OFS_CONFIG    8'h30
`define SBA_OFS_GEN_STAT  8'h34
`define SBA_OFS_X_STAT    8'h38
`define SBA_OFS_Y_STAT    8'h3A
`define SBA_OFS_X_PEAK    8'h3C
`define SBA_OFS_Y_PEAK    8'h3E
`define SBA_OFS_X_BIN     8'h44
`define SBA_OFS_Y_BIN     8'h46
// reset values
`define SBA_CONFIG_RST    16'h0080
`define SBA_ZERO16        16'h0000
// config field positions and masks
`define SBA_CFG_X_EN      0
`define SBA_CFG_Y_EN      1
`define SBA_CFG_SYS_EN    3
`define SBA_CFG_SYS_TEMP  4
`define SBA_CFG_SYS_BELOW 5
`define SBA_CFG_PIN_EN    6
`define SBA_CFG_LATCH     7
`define SBA_CFG_DLY_LO    8
`define SBA_CFG_MASK      16'h0FFB
`define SBA_PTR_MASK      16'h0307
`define SBA_PTR_BAND_LO   0
`define SBA_PTR_RATE_LO   8
// global command bits
`define SBA_CMD_CLR_STAT  4
`define SBA_CMD_CLR_BANDS 9
`define SBA_CMD_SAVE      12
`endif

/* File: pkg/sba_pkg.sv */
package sba_pkg;
    // per-band limit entry
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
    } sba_limit_t;
    // scan phase per record
    typedef enum logic [2:0] {
        SBA_IDLE = 3'b001,
        SBA_SCAN = 3'b010,
        SBA_DONE = 3'b100
    } sba_phase_t;
endpackage

/* File: pkg/sba_cmp_if.sv */
`timescale 1ns/1ns
// carries one spectral sample and its band limits to the comparator
interface sba_cmp_if;
    logic [7:0] bin;
    logic [7:0] low;
    logic [7:0] high;
    logic [15:0] mag;
    logic [15:0] warn_lvl;
    logic [15:0] fault_lvl;
    logic warn_hit;
    logic fault_hit;
    modport src(output bin, low, high, mag, warn_lvl, fault_lvl, input warn_hit, fault_hit);
    modport cmp(input bin, low, high, mag, warn_lvl, fault_lvl, output warn_hit, fault_hit);
endinterface

/* File: src/sba_band_cmp.sv */
`timescale 1ns/1ns
// combinational in-band threshold compare for one band of one axis
module sba_band_cmp
    import sba_pkg::*;
(
    sba_cmp_if.cmp c
);
    logic in_band;
    // bin inside the inclusive limits
    assign in_band = (c.bin >= c.low) && (c.bin <= c.high);
    assign c.warn_hit = in_band && (c.mag > c.warn_lvl); // RQ24
    assign c.fault_hit = in_band && (c.mag > c.fault_lvl); // RQ24
endmodule

/* File: dv/test_spectral_band_alarm_config.sv */
`timescale 1ns/1ns
`include "sba_consts.svh"
// self-checking bench: register port, band table, record scans, system alarm
module test_spectral_band_alarm_config;
    // design inputs, all given a value at time zero
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic cmd_valid_in = 1'b0;
    logic [15:0] global_command_in = 16'h0000;
    logic rec_start_in = 1'b0;
    logic rec_valid_in = 1'b0;
    logic rec_last_in = 1'b0;
    logic [1:0] rec_rate_in = 2'h0;
    logic [7:0] rec_bin_in = 8'h00;
    logic [15:0] rec_x_mag_in = 16'h0000;
    logic [15:0] rec_y_mag_in = 16'h0000;
    logic [15:0] temp_meas_in = 16'h0000;
    logic [15:0] supply_meas_in = 16'h0000;
    // design outputs
    logic [15:0] reg_rdata_out;
    logic warning_output_pin_out;
    logic fault_output_pin_out;
    logic bands_saved_out;
    // bookkeeping
    int n_fail = 0;
    int n_compared = 0;
    int seed = 81690;
    logic [7:0] lo_m [1:6][0:3]; // expected low bins per band and rate
    logic [7:0] hi_m [1:6][0:3]; // expected high bins per band and rate
    logic [15:0] mags [8] = '{16'h0064, 16'h0065, 16'h00C8, 16'h00C9, 16'h0000, 16'hFFFF,
                             16'h0000, 16'h0000};
    logic [7:0] thr_ofs [5] = '{`SBA_OFS_X_WARN, `SBA_OFS_Y_WARN, `SBA_OFS_X_FAULT,
                               `SBA_OFS_Y_FAULT, `SBA_OFS_SYS_LEVEL};
    logic [15:0] v;
    logic [2:0] b;
    logic [1:0] r;

    // 250 MHz core clock
    always #2 core_clk_in = ~core_clk_in;

    sba_alarm DUT (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .cmd_valid_in(cmd_valid_in),
        .global_command_in(global_command_in), .rec_start_in(rec_start_in),
        .rec_valid_in(rec_valid_in), .rec_last_in(rec_last_in), .rec_rate_in(rec_rate_in),
        .rec_bin_in(rec_bin_in), .rec_x_mag_in(rec_x_mag_in), .rec_y_mag_in(rec_y_mag_in),
        .temp_meas_in(temp_meas_in), .supply_meas_in(supply_meas_in),
        .warning_output_pin_out(warning_output_pin_out),
        .fault_output_pin_out(fault_output_pin_out), .bands_saved_out(bands_saved_out)
    );

    // single compare point, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write pulse, driven on the falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge core_clk_in);
        reg_wr_in = 1'b0;
    endtask

    // read is combinational, so settle a little after the address moves
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        @(negedge core_clk_in);
        reg_addr_in = a;
        #1;
        chk(reg_rdata_out & m, e);
    endtask

    // global command word pulse
    task automatic cmd(input logic [15:0] c);
        @(negedge core_clk_in);
        global_command_in = c;
        cmd_valid_in = 1'b1;
        @(negedge core_clk_in);
        cmd_valid_in = 1'b0;
    endtask

    // pointer first, then both limits, so they land in the chosen entry
    task automatic wr_lim(input logic [2:0] bb, input logic [1:0] rr, input logic [15:0] l,
                          input logic [15:0] h);
        wr(`SBA_OFS_POINTER, {6'h00, rr, 5'h00, bb});
        wr(`SBA_OFS_LOW_BIN, l);
        wr(`SBA_OFS_HIGH_BIN, h);
        if (bb >= 3'd1 && bb <= 3'd6) begin
            lo_m[bb][rr] = l[7:0];
            hi_m[bb][rr] = h[7:0];
        end
    endtask

    // one-bin record on rate 0 at bin 15; status settles two edges after the last bin
    task automatic send_rec(input logic [15:0] xm, input logic [15:0] ym);
        @(negedge core_clk_in);
        rec_start_in = 1'b1;
        @(negedge core_clk_in);
        rec_start_in = 1'b0;
        rec_valid_in = 1'b1;
        rec_last_in = 1'b1;
        rec_bin_in = 8'd15;
        rec_x_mag_in = xm;
        rec_y_mag_in = ym;
        @(negedge core_clk_in);
        rec_valid_in = 1'b0;
        rec_last_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
    endtask

    // band 1 status word: fault bit 5, warning bit 4, critical band in 2:0
    function automatic logic [15:0] stat_exp(input logic w, input logic f);
        return {10'h000, f, w, 1'b0, 2'b00, w | f};
    endfunction

    // system alarm from config bits 5:3 (below, temperature, enable)
    function automatic logic sys_exp(input logic [2:0] c, input logic [15:0] t,
                                     input logic [15:0] s, input logic [15:0] lvl);
        logic [15:0] m;
        m = c[1] ? t : s;
        if (!c[0]) return 1'b0;
        return c[2] ? (m < lvl) : (m > lvl);
    endfunction

    task automatic final_report();
        $display("summary: %0d compared, %0d mismatched", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog, well beyond the run's length
    initial begin
        #100000;
        n_fail++;
        final_report();
    end

    initial begin
        repeat (5) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        rd(`SBA_OFS_CONFIG, 16'h0080);
        rd(`SBA_OFS_POINTER, 16'h0000);
        rd(`SBA_OFS_LOW_BIN, 16'h0000);
        wr(`SBA_OFS_CONFIG, 16'hFFFF);
        rd(`SBA_OFS_CONFIG, 16'h0FFB);
        wr(`SBA_OFS_POINTER, 16'hFFFF);
        rd(`SBA_OFS_POINTER, 16'h0307);
        wr(`SBA_OFS_CONFIG, 16'h0080);
        $display("reset and reserved bits test done");
        // fill every entry, overwrite some at random, then try illegal bands 0 and 7
        for (int i = 0; i < 24; i++) wr_lim(3'(1 + i / 4), 2'(i % 4), $random(seed), $random(seed));
        for (int i = 0; i < 16; i++) begin
            b = 3'(1 + $unsigned($random(seed)) % 6);
            r = 2'($random(seed));
            wr_lim(b, r, $random(seed), $random(seed));
        end
        wr_lim(3'd7, 2'd0, 16'h00AA, 16'h00AA);
        wr_lim(3'd0, 2'd1, 16'h0055, 16'h0055);
        for (int i = 0; i < 24; i++) begin
            wr(`SBA_OFS_POINTER, {6'h00, 2'(i % 4), 5'h00, 3'(1 + i / 4)});
            rd(`SBA_OFS_LOW_BIN, {8'h00, lo_m[1 + i / 4][i % 4]});
            rd(`SBA_OFS_HIGH_BIN, {8'h00, hi_m[1 + i / 4][i % 4]});
        end
        $display("band table test done");
        foreach (thr_ofs[i]) begin
            v = $random(seed);
            wr(thr_ofs[i], v);
            rd(thr_ofs[i], v);
        end
        wr(`SBA_OFS_X_STAT, 16'hFFFF);
        rd(`SBA_OFS_X_STAT, 16'h0000);
        rd(8'h40, 16'h0000);
        $display("threshold and read-only test done");
        cmd(16'h0200);
        rd(`SBA_OFS_LOW_BIN, 16'h0000);
        cmd(16'h1000);
        chk({15'h0000, bands_saved_out}, 16'h0001);
        cmd(16'h0200);
        chk({15'h0000, bands_saved_out}, 16'h0000);
        wr_lim(3'd1, 2'd0, 16'h000A, 16'h0014);
        cmd(16'h1000);
        chk({15'h0000, bands_saved_out}, 16'h0000);
        $display("clear and save test done");
        // band 1 spans bins 10..20 on rate 0; warning 100, fault 200
        wr(`SBA_OFS_X_WARN, 16'h0064);
        wr(`SBA_OFS_Y_WARN, 16'h0064);
        wr(`SBA_OFS_X_FAULT, 16'h00C8);
        wr(`SBA_OFS_Y_FAULT, 16'h00C8);
        wr(`SBA_OFS_CONFIG, 16'h0141);
        send_rec(16'h0096, 16'h0000);
        rd(`SBA_OFS_X_STAT, 16'h0000, 16'hFFF0);
        send_rec(16'h0096, 16'h0000);
        rd(`SBA_OFS_X_STAT, 16'h0011);
        chk({15'h0000, warning_output_pin_out}, 16'h0001);
        chk({15'h0000, fault_output_pin_out}, 16'h0000);
        wr(`SBA_OFS_CONFIG, 16'h0043);
        send_rec(16'h00FA, 16'h0032);
        rd(`SBA_OFS_X_STAT, 16'h0031);
        rd(`SBA_OFS_Y_STAT, 16'h0000);
        rd(`SBA_OFS_X_PEAK, 16'h00FA);
        rd(`SBA_OFS_X_BIN, 16'h000F);
        chk({15'h0000, fault_output_pin_out}, 16'h0001);
        wr(`SBA_OFS_CONFIG, 16'h0003);
        send_rec(16'h00FA, 16'h0096);
        chk({15'h0000, fault_output_pin_out}, 16'h0000);
        rd(`SBA_OFS_Y_STAT, 16'h0011);
        wr(`SBA_OFS_CONFIG, 16'h0002);
        send_rec(16'h00FA, 16'h0096);
        rd(`SBA_OFS_X_STAT, 16'h0000);
        rd(`SBA_OFS_Y_STAT, 16'h0011);
        // threshold boundaries plus random magnitudes, strictly-greater compare
        wr(`SBA_OFS_CONFIG, 16'h0003);
        mags[6] = $random(seed);
        mags[7] = 16'($unsigned($random(seed)) % 300);
        foreach (mags[i]) begin
            send_rec(mags[i], 16'h0000);
            rd(`SBA_OFS_X_STAT, stat_exp(mags[i] > 16'h0064, mags[i] > 16'h00C8));
        end
        $display("spectral record test done");
        wr(`SBA_OFS_SYS_LEVEL, 16'h1000);
        temp_meas_in = 16'h2000;
        supply_meas_in = 16'h0800;
        for (int c = 0; c < 8; c++) begin
            wr(`SBA_OFS_CONFIG, {10'h000, 3'(c), 3'h0});
            send_rec(16'h0000, 16'h0000);
            v = {15'h0000, sys_exp(3'(c), temp_meas_in, supply_meas_in, 16'h1000)};
            rd(`SBA_OFS_GEN_STAT, v, 16'h0001);
        end
        // latched flag survives the cause going away until clear status
        wr(`SBA_OFS_CONFIG, 16'h0098);
        send_rec(16'h0000, 16'h0000);
        rd(`SBA_OFS_GEN_STAT, 16'h0001, 16'h0001);
        temp_meas_in = 16'h0000;
        send_rec(16'h0000, 16'h0000);
        rd(`SBA_OFS_GEN_STAT, 16'h0001, 16'h0001);
        cmd(16'h0010);
        rd(`SBA_OFS_GEN_STAT, 16'h0000, 16'h0001);
        $display("system alarm test done");
        final_report();
    end
endmodule
